// *** logic/tbp_consts.vh ***
`ifndef TBP_CONSTS_VH
`define TBP_CONSTS_VH
// block base and register indexes (byte address = 4 * low six bits of index)
`define TBP_BASE 32'h50003400
`define TBP_IDX_T0_CTRL 32'h50003400
`define TBP_IDX_ON 32'h50003402
`define TBP_IDX_HIGH 32'h50003404
`define TBP_IDX_LOW 32'h50003406
`define TBP_IDX_A_RISE 32'h50003408
`define TBP_IDX_B_RISE 32'h5000340A
`define TBP_IDX_C_RISE 32'h5000340C
`define TBP_IDX_A_FALL 32'h5000340E
`define TBP_IDX_B_FALL 32'h50003410
`define TBP_IDX_C_FALL 32'h50003412
`define TBP_IDX_PERIOD 32'h50003414
`define TBP_IDX_TRI_CTRL 32'h50003416
`define TBP_IDX_BR_CFG 32'h50003418
`define TBP_IDX_BR_MAX 32'h5000341A
`define TBP_IDX_BR_MIN 32'h5000341C
`define TBP_IDX_BR_CTRL 32'h5000341E
// decoded word slot: awaddr[7:2] equals low six bits of index
`define TBP_SLOT_MSB 7
`define TBP_SLOT_LSB 2
`define TBP_SLOT_W 6
// field positions
`define TBP_POS_W 14
`define TBP_TRI_CLK_SEL 3
`define TBP_TRI_HW_HOLD 2
`define TBP_TRI_SW_HOLD 1
`define TBP_TRI_EN 0
`define TBP_T0_RUN 0
`define TBP_BR_RUN 0
`define TBP_BR_POL 1
// reset values
`define TBP_TRI_CTRL_RST 4'hC
`define TBP_BR_STEP_RST 8'h01
`define TBP_BR_DIV_RST 8'hFF
`define TBP_BR_MAX_RST 8'h0A
`define TBP_BR_MIN_RST 8'h01
// timing
`define TBP_SYS_HZ 100000000
`define TBP_SLOW_HZ 32000
`define TBP_SLOW_CYC (`TBP_SYS_HZ / `TBP_SLOW_HZ)
`define TBP_BR_HZ 16000000
`define TBP_BR_CYC (`TBP_SYS_HZ / `TBP_BR_HZ)
`define TBP_DIV_W 12
// axi responses
`define TBP_RESP_OKAY 2'h0
`define TBP_RESP_SLVERR 2'h2
`endif

// *** logic/tbp_pwm_chan.v ***
`include "tbp_consts.vh"
module tbp_pwm_chan
(
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // shared timing
  input wire runEn,
  input wire [`TBP_POS_W-1:0] periodSet,
  input wire [`TBP_POS_W-1:0] periodCnt,
  // channel settings
  input wire [`TBP_POS_W-1:0] risePos,
  input wire [`TBP_POS_W-1:0] fallPos,
  // pin
  output reg chanOut
);
  wire forcedLow;
  wire forcedHigh;
  assign forcedLow = (risePos > periodSet) || (fallPos == risePos);
  assign forcedHigh = (fallPos > periodSet) && !(risePos > periodSet);
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      chanOut <= 1'b0;
    else if (!runEn || forcedLow)
      chanOut <= 1'b0;
    else if (forcedHigh)
      chanOut <= 1'b1;
    else if (periodCnt == risePos)
      chanOut <= 1'b1;
    else if (periodCnt == fallPos)
      chanOut <= 1'b0;
  end
endmodule // tbp_pwm_chan

// *** logic/tbp_timer_pwm.v ***
// Overview of operation
// - writing on-time reload sets reload; reading returns live on-time counter.
// - writing high-phase reload sets reload; reading returns main phase counter.
// - writing low-phase reload sets reload; reading returns main phase counter.
// - each channel rises when shared counter reaches its 14-bit rise position.
// - channel stays low if rise exceeds period or fall equals rise.
// - each channel falls when shared counter reaches its 14-bit fall position.
// - channel stays high if fall exceeds period and rise does not.
// - one shared 14-bit period; period is timer clock times setting plus one.
// - control bit 3 picks fast clock (1) or slow clock (0); resets 1.
// - control bit 2 lets hardware pause the channels; resets 1.
// - control bit 0 enables the three-channel generator; resets 0.
// - step field 15:8 holds duty for step plus one breath periods; resets 1.
// - divider field 7:0 sets breath rate 16MHz over divider plus one; resets FF.
// - ceiling value sets highest breath duty; resets 0xA.
// - floor value sets lowest breath duty; resets 0x1.
// - timer run bit 0 holds timer in reset; 1 lets it run.
// - breath run bit starts breathing; resets 0.
// - breath idle-level bit sets output level while idle.
//
// Chosen here: the AXI4-Lite register port.
`include "tbp_consts.vh"
module tbp_timer_pwm
(
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // axi4-lite write address
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // system hold request
  input wire hwHoldReq,
  // pins
  output reg timerAOut,
  output wire [2:0] chanOut,
  output reg rampOut
);
  // registers
  reg timerARun_reg;
  reg [15:0] onTimeReload_reg;
  reg [15:0] highPhaseReload_reg;
  reg [15:0] lowPhaseReload_reg;
  reg [`TBP_POS_W-1:0] riseA_reg;
  reg [`TBP_POS_W-1:0] riseB_reg;
  reg [`TBP_POS_W-1:0] riseC_reg;
  reg [`TBP_POS_W-1:0] fallA_reg;
  reg [`TBP_POS_W-1:0] fallB_reg;
  reg [`TBP_POS_W-1:0] fallC_reg;
  reg [`TBP_POS_W-1:0] periodSet_reg;
  reg [3:0] triCtrl_reg;
  reg [7:0] rampHoldPeriods_reg;
  reg [7:0] rampClockDivider_reg;
  reg [7:0] rampDutyCeiling_reg;
  reg [7:0] rampDutyFloor_reg;
  reg rampRun_reg;
  reg rampIdleLevel_reg;
  // axi write side
  reg awHave_reg;
  reg wHave_reg;
  reg [`TBP_SLOT_W-1:0] awSlot_reg;
  reg awHit_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  wire wrGo;
  wire [15:0] wMerged;
  // timer a
  reg [15:0] onTimeCounter_reg;
  reg [15:0] mainPhaseCounter_reg;
  reg phaseHigh_reg;
  // shared period
  reg [`TBP_DIV_W-1:0] slowDiv_reg;
  reg [`TBP_POS_W-1:0] periodCnt_reg;
  wire slowTick;
  wire [31:0] slowReload;
  wire triTick;
  wire triRun;
  wire triHeld;
  // breath
  reg [`TBP_DIV_W-1:0] brDiv_reg;
  reg [7:0] brCnt_reg;
  reg [7:0] brHold_reg;
  reg [7:0] brDuty_reg;
  reg brUp_reg;
  wire brTick;
  wire [31:0] brReload;
  wire brWrap;

  // slot decode helper
  function [`TBP_SLOT_W-1:0] slotOf;
    input [31:0] idx;
    begin
      slotOf = idx[`TBP_SLOT_W-1:0];
    end
  endfunction

  function isMapped;
    input [31:0] addr;
    reg [`TBP_SLOT_W-1:0] s;
    begin
      s = addr[`TBP_SLOT_MSB:`TBP_SLOT_LSB];
      isMapped = (addr[1:0] == 2'h0) && (addr[31:`TBP_SLOT_MSB+1] == 24'h000000)
        && (s <= slotOf(`TBP_IDX_BR_CTRL));
    end
  endfunction

  // write channel: address and data taken independently, response after both
  assign s_axi_awready = !awHave_reg && !s_axi_bvalid;
  assign s_axi_wready = !wHave_reg && !s_axi_bvalid;
  assign wrGo = awHave_reg && wHave_reg && !s_axi_bvalid;
  assign wMerged = {wStrb_reg[1] ? wData_reg[15:8] : 8'h00,
    wStrb_reg[0] ? wData_reg[7:0] : 8'h00};

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awSlot_reg <= 6'h00;
      awHit_reg <= 1'b0;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TBP_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_reg <= 1'b1;
        awSlot_reg <= s_axi_awaddr[`TBP_SLOT_MSB:`TBP_SLOT_LSB];
        awHit_reg <= isMapped(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrGo)
      begin
        awHave_reg <= 1'b0;
        wHave_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= awHit_reg ? `TBP_RESP_OKAY : `TBP_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // register writes (only bytes with strobe merge; unstrobed bytes are written as zero)
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      timerARun_reg <= 1'b0;
      onTimeReload_reg <= 16'h0000;
      highPhaseReload_reg <= 16'h0000;
      lowPhaseReload_reg <= 16'h0000;
      riseA_reg <= 14'h0000;
      riseB_reg <= 14'h0000;
      riseC_reg <= 14'h0000;
      fallA_reg <= 14'h0000;
      fallB_reg <= 14'h0000;
      fallC_reg <= 14'h0000;
      periodSet_reg <= 14'h0000;
      triCtrl_reg <= `TBP_TRI_CTRL_RST;
      rampHoldPeriods_reg <= `TBP_BR_STEP_RST;
      rampClockDivider_reg <= `TBP_BR_DIV_RST;
      rampDutyCeiling_reg <= `TBP_BR_MAX_RST;
      rampDutyFloor_reg <= `TBP_BR_MIN_RST;
      rampRun_reg <= 1'b0;
      rampIdleLevel_reg <= 1'b0;
    end
    else if (wrGo && awHit_reg && wStrb_reg[1:0] != 2'h0)
    begin
      case (awSlot_reg)
        slotOf(`TBP_IDX_T0_CTRL): timerARun_reg <= wMerged[`TBP_T0_RUN];
        slotOf(`TBP_IDX_ON): onTimeReload_reg <= wMerged;
        slotOf(`TBP_IDX_HIGH): highPhaseReload_reg <= wMerged;
        slotOf(`TBP_IDX_LOW): lowPhaseReload_reg <= wMerged;
        slotOf(`TBP_IDX_A_RISE): riseA_reg <= wMerged[`TBP_POS_W-1:0];
        slotOf(`TBP_IDX_B_RISE): riseB_reg <= wMerged[`TBP_POS_W-1:0];
        slotOf(`TBP_IDX_C_RISE): riseC_reg <= wMerged[`TBP_POS_W-1:0];
        slotOf(`TBP_IDX_A_FALL): fallA_reg <= wMerged[`TBP_POS_W-1:0];
        slotOf(`TBP_IDX_B_FALL): fallB_reg <= wMerged[`TBP_POS_W-1:0];
        slotOf(`TBP_IDX_C_FALL): fallC_reg <= wMerged[`TBP_POS_W-1:0];
        slotOf(`TBP_IDX_PERIOD): periodSet_reg <= wMerged[`TBP_POS_W-1:0];
        slotOf(`TBP_IDX_TRI_CTRL): triCtrl_reg <= wMerged[3:0];
        slotOf(`TBP_IDX_BR_CFG):
        begin
          rampHoldPeriods_reg <= wMerged[15:8];
          rampClockDivider_reg <= wMerged[7:0];
        end
        slotOf(`TBP_IDX_BR_MAX): rampDutyCeiling_reg <= wMerged[7:0];
        slotOf(`TBP_IDX_BR_MIN): rampDutyFloor_reg <= wMerged[7:0];
        slotOf(`TBP_IDX_BR_CTRL):
        begin
          rampRun_reg <= wMerged[`TBP_BR_RUN];
          rampIdleLevel_reg <= wMerged[`TBP_BR_POL];
        end
        default: timerARun_reg <= timerARun_reg;
      endcase
    end
  end

  // read channel: one cycle to data
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TBP_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= isMapped(s_axi_araddr) ? `TBP_RESP_OKAY : `TBP_RESP_SLVERR;
      case (s_axi_araddr[`TBP_SLOT_MSB:`TBP_SLOT_LSB])
        slotOf(`TBP_IDX_T0_CTRL): s_axi_rdata <= {31'h00000000, timerARun_reg};
        slotOf(`TBP_IDX_ON): s_axi_rdata <= {16'h0000, onTimeCounter_reg};
        slotOf(`TBP_IDX_HIGH): s_axi_rdata <= {16'h0000, mainPhaseCounter_reg};
        slotOf(`TBP_IDX_LOW): s_axi_rdata <= {16'h0000, mainPhaseCounter_reg};
        slotOf(`TBP_IDX_A_RISE): s_axi_rdata <= {18'h00000, riseA_reg};
        slotOf(`TBP_IDX_B_RISE): s_axi_rdata <= {18'h00000, riseB_reg};
        slotOf(`TBP_IDX_C_RISE): s_axi_rdata <= {18'h00000, riseC_reg};
        slotOf(`TBP_IDX_A_FALL): s_axi_rdata <= {18'h00000, fallA_reg};
        slotOf(`TBP_IDX_B_FALL): s_axi_rdata <= {18'h00000, fallB_reg};
        slotOf(`TBP_IDX_C_FALL): s_axi_rdata <= {18'h00000, fallC_reg};
        slotOf(`TBP_IDX_PERIOD): s_axi_rdata <= {18'h00000, periodSet_reg};
        slotOf(`TBP_IDX_TRI_CTRL): s_axi_rdata <= {28'h0000000, triCtrl_reg};
        slotOf(`TBP_IDX_BR_CFG):
          s_axi_rdata <= {16'h0000, rampHoldPeriods_reg, rampClockDivider_reg};
        slotOf(`TBP_IDX_BR_MAX): s_axi_rdata <= {24'h000000, rampDutyCeiling_reg};
        slotOf(`TBP_IDX_BR_MIN): s_axi_rdata <= {24'h000000, rampDutyFloor_reg};
        slotOf(`TBP_IDX_BR_CTRL):
          s_axi_rdata <= {30'h00000000, rampIdleLevel_reg, rampRun_reg};
        default: s_axi_rdata <= 32'h00000000;
      endcase
      if (!isMapped(s_axi_araddr))
        s_axi_rdata <= 32'h00000000;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // timer a: on-time counter and high/low main phase counter
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      onTimeCounter_reg <= 16'h0000;
      mainPhaseCounter_reg <= 16'h0000;
      phaseHigh_reg <= 1'b1;
      timerAOut <= 1'b0;
    end
    else if (!timerARun_reg)
    begin
      onTimeCounter_reg <= onTimeReload_reg;
      mainPhaseCounter_reg <= highPhaseReload_reg;
      phaseHigh_reg <= 1'b1;
      timerAOut <= 1'b0;
    end
    else
    begin
      onTimeCounter_reg <= (onTimeCounter_reg == 16'h0000) ? onTimeReload_reg
        : onTimeCounter_reg - 16'h0001;
      timerAOut <= phaseHigh_reg;
      if (mainPhaseCounter_reg == 16'h0000)
      begin
        phaseHigh_reg <= !phaseHigh_reg;
        mainPhaseCounter_reg <= phaseHigh_reg ? lowPhaseReload_reg : highPhaseReload_reg;
      end
      else
        mainPhaseCounter_reg <= mainPhaseCounter_reg - 16'h0001;
    end
  end

  // shared period counter for the three channels
  assign slowTick = (slowDiv_reg == 12'h000);
  assign slowReload = `TBP_SLOW_CYC - 1;
  assign triTick = triCtrl_reg[`TBP_TRI_CLK_SEL] ? 1'b1 : slowTick;
  assign triHeld = triCtrl_reg[`TBP_TRI_SW_HOLD]
    || (triCtrl_reg[`TBP_TRI_HW_HOLD] && hwHoldReq);
  assign triRun = triCtrl_reg[`TBP_TRI_EN];

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      slowDiv_reg <= 12'h000;
      periodCnt_reg <= 14'h0000;
    end
    else
    begin
      slowDiv_reg <= slowTick ? slowReload[`TBP_DIV_W-1:0] : slowDiv_reg - 12'h001;
      if (!triRun)
        periodCnt_reg <= 14'h0000;
      else if (triTick && !triHeld)
        periodCnt_reg <= (periodCnt_reg >= periodSet_reg) ? 14'h0000
          : periodCnt_reg + 14'h0001;
    end
  end

  tbp_pwm_chan chanA
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .runEn(triRun),
    .periodSet(periodSet_reg),
    .periodCnt(periodCnt_reg),
    .risePos(riseA_reg),
    .fallPos(fallA_reg),
    .chanOut(chanOut[0])
  );
  tbp_pwm_chan chanB
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .runEn(triRun),
    .periodSet(periodSet_reg),
    .periodCnt(periodCnt_reg),
    .risePos(riseB_reg),
    .fallPos(fallB_reg),
    .chanOut(chanOut[1])
  );
  tbp_pwm_chan chanC
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .runEn(triRun),
    .periodSet(periodSet_reg),
    .periodCnt(periodCnt_reg),
    .risePos(riseC_reg),
    .fallPos(fallC_reg),
    .chanOut(chanOut[2])
  );

  // breathing output
  assign brTick = (brDiv_reg == 12'h000);
  assign brReload = `TBP_BR_CYC - 1;
  assign brWrap = brTick && (brCnt_reg >= rampClockDivider_reg);

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      brDiv_reg <= 12'h000;
      brCnt_reg <= 8'h00;
      brHold_reg <= 8'h00;
      brDuty_reg <= `TBP_BR_MIN_RST;
      brUp_reg <= 1'b1;
      rampOut <= 1'b0;
    end
    else if (!rampRun_reg)
    begin
      brDiv_reg <= 12'h000;
      brCnt_reg <= 8'h00;
      brHold_reg <= 8'h00;
      brDuty_reg <= rampDutyFloor_reg;
      brUp_reg <= 1'b1;
      rampOut <= rampIdleLevel_reg;
    end
    else
    begin
      brDiv_reg <= brTick ? brReload[`TBP_DIV_W-1:0] : brDiv_reg - 12'h001;
      rampOut <= (brCnt_reg < brDuty_reg) ^ rampIdleLevel_reg;
      if (brTick)
        brCnt_reg <= brWrap ? 8'h00 : brCnt_reg + 8'h01;
      if (brWrap)
      begin
        if (brHold_reg >= rampHoldPeriods_reg)
        begin
          brHold_reg <= 8'h00;
          if (brUp_reg)
          begin
            if (brDuty_reg >= rampDutyCeiling_reg)
            begin
              brUp_reg <= 1'b0;
              brDuty_reg <= rampDutyCeiling_reg;
            end
            else
              brDuty_reg <= brDuty_reg + 8'h01;
          end
          else if (brDuty_reg <= rampDutyFloor_reg)
          begin
            brUp_reg <= 1'b1;
            brDuty_reg <= rampDutyFloor_reg;
          end
          else
            brDuty_reg <= brDuty_reg - 8'h01;
        end
        else
          brHold_reg <= brHold_reg + 8'h01;
      end
    end
  end
endmodule // tbp_timer_pwm

// *** sim/tbp_timer_pwm_chk.sv ***
`include "tbp_consts.vh"
module tbp_timer_pwm_chk
(
  // clock and reset
  input logic sys_clk,
  input logic reset,
  // register bus
  input logic [31:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [31:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // hold request and pins
  input logic hwHoldReq,
  input logic timerAOut,
  input logic [2:0] chanOut,
  input logic rampOut
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wrHit;
  logic [3:0] triSh;
  logic t0Sh;
  logic [1:0] brSh;
  // shadow of the control words, taken at the write handshake
  assign wrHit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      triSh <= `TBP_TRI_CTRL_RST;
      t0Sh <= 1'b0;
      brSh <= 2'h0;
    end
    else if (wrHit && s_axi_awaddr == 32'h58)
      triSh <= s_axi_wdata[3:0];
    else if (wrHit && s_axi_awaddr == 32'h0)
      t0Sh <= s_axi_wdata[0];
    else if (wrHit && s_axi_awaddr == 32'h78)
      brSh <= s_axi_wdata[1:0];
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  read_gate_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  write_answer_a: assert property (wrHit |-> ##[1:3] s_axi_bvalid) else $error("no write answer");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[31:8] != 24'h0
    |=> s_axi_rvalid && s_axi_rresp == `TBP_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
  tri_off_a: assert property ((!triSh[0]) [*4] |-> chanOut == 3'h0)
    else $error("channel active while disabled");
  timer_off_a: assert property ((!t0Sh) [*4] |-> !timerAOut)
    else $error("timer output while stopped");
  ramp_idle_a: assert property ((!brSh[0] && $stable(brSh[1])) [*4] |-> rampOut == brSh[1])
    else $error("ramp output not at idle level");
  chan_hold_a: assert property ((triSh[0] && (triSh[1] || triSh[2] && hwHoldReq)) [*4]
    |-> $stable(chanOut)) else $error("channels moved while held");
  cover property (wrHit);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(chanOut[0]));
  cover property ($rose(rampOut));
endmodule // tbp_timer_pwm_chk
bind tbp_timer_pwm tbp_timer_pwm_chk tbp_timer_pwm_chk_inst (.*);

// *** sim/tbp_led_load.sv ***
module tbp_led_load
(
  // clock
  input logic sys_clk,
  // window restart
  input logic clr,
  // driven loads
  input logic [4:0] lines,
  // high-time tallies
  output logic [4:0][15:0] hiCnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // each load tallies the cycles its line is high
  always_ff @(posedge sys_clk)
    for (int i = 0; i < 5; i++)
      hiCnt[i] <= clr ? 16'h0 : hiCnt[i] + {15'h0, lines[i]};
endmodule // tbp_led_load

// *** sim/test_timer_triple_pwm_breath.sv ***
`include "tbp_consts.vh"
module test_timer_triple_pwm_breath;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, hwHoldReq = 1'b0, winClr = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire timerAOut, rampOut;
  wire [2:0] chanOut;
  wire [4:0][15:0] hiCnt;
  int miscompares = 0;
  int n_tests = 0;
  logic [31:0] rdVal;
  logic [1:0] rdResp;
  always #5 sys_clk = ~sys_clk;
  tbp_timer_pwm tbp_timer_pwm_inst (.*);
  tbp_led_load tbp_led_load_inst (.sys_clk(sys_clk), .clr(winClr),
    .lines({timerAOut, rampOut, chanOut}), .hiCnt(hiCnt));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkFlag(input logic f);
    n_tests++;
    if (f !== 1'b1)
    begin
      miscompares++;
      $display("BAD %0t condition false", $time);
    end
  endtask
  task automatic bound(input int n);
    if (n >= 40)
    begin
      miscompares++;
      $display("BAD %0t bus wait ran out", $time);
      conclude();
    end
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      n++;
    end
    while (!s_axi_bvalid && n < 40);
    bound(n);
    r = s_axi_bresp;
  endtask
  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      n++;
    end
    while (!s_axi_rvalid && n < 40);
    bound(n);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // register index to byte address
  task automatic wr(input logic [31:0] idx, input logic [31:0] d);
    axw({24'h0, idx[5:0], 2'h0}, d, rdResp);
    chkVal({30'h0, rdResp}, {30'h0, `TBP_RESP_OKAY});
  endtask
  task automatic rd(input logic [31:0] idx, input logic [31:0] exp);
    axr({24'h0, idx[5:0], 2'h0}, rdVal, rdResp);
    chkVal({30'h0, rdResp}, {30'h0, `TBP_RESP_OKAY});
    chkVal(rdVal, exp);
  endtask
  // settle, restart the tallies, then count n cycles
  task automatic win(input int n);
    repeat (4) @(posedge sys_clk);
    winClr <= 1'b1;
    @(posedge sys_clk);
    winClr <= 1'b0;
    repeat (n + 1) @(posedge sys_clk);
  endtask
  task automatic t_reset();
    rd(`TBP_IDX_TRI_CTRL, 32'hC);
    rd(`TBP_IDX_BR_CFG, 32'h1FF);
    rd(`TBP_IDX_BR_MAX, 32'hA);
    rd(`TBP_IDX_BR_MIN, 32'h1);
    rd(`TBP_IDX_BR_CTRL, 32'h0);
    rd(`TBP_IDX_PERIOD, 32'h0);
    $display("reset values done");
  endtask
  task automatic t_regs();
    wr(`TBP_IDX_B_RISE, 32'h3FFF);
    rd(`TBP_IDX_B_RISE, 32'h3FFF);
    wr(`TBP_IDX_C_FALL, 32'h1234);
    rd(`TBP_IDX_C_FALL, 32'h1234);
    axw(32'h22, 32'h5, rdResp);
    chkVal({30'h0, rdResp}, {30'h0, `TBP_RESP_SLVERR});
    axr(32'h100, rdVal, rdResp);
    chkVal({30'h0, rdResp}, {30'h0, `TBP_RESP_SLVERR});
    chkVal(rdVal, 32'h0);
    $display("register access done");
  endtask
  task automatic t_timer();
    wr(`TBP_IDX_ON, 32'h5);
    wr(`TBP_IDX_HIGH, 32'h3);
    wr(`TBP_IDX_LOW, 32'h2);
    rd(`TBP_IDX_ON, 32'h5);
    rd(`TBP_IDX_HIGH, 32'h3);
    rd(`TBP_IDX_LOW, 32'h3);
    wr(`TBP_IDX_T0_CTRL, 32'h1);
    win(98);
    chkVal({16'h0, hiCnt[4]}, 32'h38);
    axr({24'h0, 6'h02, 2'h0}, rdVal, rdResp);
    chkFlag(rdVal <= 32'h5);
    wr(`TBP_IDX_T0_CTRL, 32'h0);
    rd(`TBP_IDX_ON, 32'h5);
    $display("timer done");
  endtask
  task automatic t_pwm();
    wr(`TBP_IDX_PERIOD, 32'h9);
    wr(`TBP_IDX_A_RISE, 32'h2);
    wr(`TBP_IDX_A_FALL, 32'h5);
    wr(`TBP_IDX_B_RISE, 32'hC);
    wr(`TBP_IDX_B_FALL, 32'h3);
    wr(`TBP_IDX_C_RISE, 32'h0);
    wr(`TBP_IDX_C_FALL, 32'h14);
    wr(`TBP_IDX_TRI_CTRL, 32'h9);
    win(100);
    chkVal({16'h0, hiCnt[0]}, 32'h1E);
    chkVal({16'h0, hiCnt[1]}, 32'h0);
    chkVal({16'h0, hiCnt[2]}, 32'h64);
    wr(`TBP_IDX_B_RISE, 32'h4);
    wr(`TBP_IDX_B_FALL, 32'h4);
    win(100);
    chkVal({16'h0, hiCnt[1]}, 32'h0);
    $display("three channels done");
  endtask
  task automatic t_hold();
    hwHoldReq <= 1'b1;
    win(100);
    chkVal({16'h0, hiCnt[0]}, 32'h1E);
    wr(`TBP_IDX_TRI_CTRL, 32'hD);
    win(100);
    chkFlag(hiCnt[0] == 16'h0 || hiCnt[0] == 16'h64);
    hwHoldReq <= 1'b0;
    win(100);
    chkVal({16'h0, hiCnt[0]}, 32'h1E);
    wr(`TBP_IDX_TRI_CTRL, 32'hB);
    win(100);
    chkFlag(hiCnt[0] == 16'h0 || hiCnt[0] == 16'h64);
    $display("hold done");
  endtask
  task automatic t_slow();
    wr(`TBP_IDX_TRI_CTRL, 32'h0);
    wr(`TBP_IDX_PERIOD, 32'h1);
    wr(`TBP_IDX_A_RISE, 32'h0);
    wr(`TBP_IDX_A_FALL, 32'h1);
    wr(`TBP_IDX_TRI_CTRL, 32'h1);
    win(2 * `TBP_SLOW_CYC);
    win(2 * `TBP_SLOW_CYC);
    chkVal({16'h0, hiCnt[0]}, `TBP_SLOW_CYC);
    $display("slow clock done");
  endtask
  task automatic t_breath();
    wr(`TBP_IDX_BR_CTRL, 32'h2);
    win(60);
    chkVal({16'h0, hiCnt[3]}, 32'h3C);
    wr(`TBP_IDX_BR_CFG, 32'h109);
    wr(`TBP_IDX_BR_MAX, 32'h3);
    wr(`TBP_IDX_BR_MIN, 32'h3);
    wr(`TBP_IDX_BR_CTRL, 32'h1);
    win(600);
    chkVal({16'h0, hiCnt[3]}, 32'hB4);
    wr(`TBP_IDX_BR_CTRL, 32'h3);
    win(600);
    chkVal({16'h0, hiCnt[3]}, 32'h1A4);
    wr(`TBP_IDX_BR_MIN, 32'h1);
    wr(`TBP_IDX_BR_CTRL, 32'h1);
    win(480);
    win(1440);
    chkVal({16'h0, hiCnt[3]}, 32'h120);
    $display("breathing done");
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_regs();
    t_timer();
    t_pwm();
    t_hold();
    t_slow();
    t_breath();
    conclude();
  end
endmodule // test_timer_triple_pwm_breath
